/* mrf_client_model.sv */
// client logic model at the receive stream: tallies good and bad frames
// assumes the stream of one mrf_top on the same clock
`timescale 1ns/1ps
`default_nettype none
module mrf_client_model (
   input wire clk,
   input wire rx_axis_tvalid,
   input wire rx_axis_tlast,
   input wire rx_axis_tuser,
   output logic [7:0] good_cnt = 8'h00,
   output logic [7:0] bad_cnt = 8'h00
);
   // no ready exists, so every beat is taken; bad frame data is never kept
   always @(posedge clk)
      if (rx_axis_tvalid && rx_axis_tlast)
      begin
         good_cnt <= good_cnt + {7'h00, rx_axis_tuser};
         bad_cnt <= bad_cnt + {7'h00, !rx_axis_tuser};
      end
endmodule // mrf_client_model
`default_nettype wire

/* mrf_consts.vh */
// constants for the receive stream and fault gate block
// included by the fault gate and top design files; definitions only
`ifndef MRF_CONSTS_VH
`define MRF_CONSTS_VH

// management map
`define MRF_ADDR_W 11
`define MRF_CFG_ADDR 11'h300
`define MRF_CFG_RESET 32'h00000000
`define MRF_OVR_BIT 27
`define MRF_LF_BIT 28
`define MRF_RF_BIT 29

// status vector layout
`define MRF_SV_LF_BIT 0
`define MRF_SV_RF_BIT 1

// frame checks
`define MRF_MIN_FRAME 8'h40
`define MRF_BEAT_BYTES 8'h08

// ten gigabit media independent interface codes
`define MRF_XG_IDLE 8'h07
`define MRF_XG_START 8'hfb
`define MRF_XG_TERM 8'hfd
`define MRF_XG_SEQ 8'h9c
`define MRF_XG_RF_CODE 8'h02
`define MRF_XG_ZERO 8'h00

`endif

/* mrf_fault_gate.v */
// transmit fault gate of the reconciliation sublayer
// assumes mac_txd/mac_txc arrive in xgmii coding on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "mrf_consts.vh"

module mrf_fault_gate (
   input wire clk,
   input wire rst_n,
   input wire override,
   input wire local_flt,
   input wire remote_flt,
   input wire [63:0] mac_txd,
   input wire [7:0] mac_txc,
   output reg [63:0] xgmii_txd,
   output reg [7:0] xgmii_txc,
   output reg dropping
);

reg has_term;
integer i;
wire sop;
wire faulted;

assign sop = mac_txc[0] && (mac_txd[7:0] == `MRF_XG_START);
assign faulted = !override && (local_flt || remote_flt);

// terminate may sit in any lane
always @*
begin
   has_term = 1'b0;
   for (i = 0; i < 8; i = i + 1)
      if (mac_txc[i] && (mac_txd[8*i +: 8] == `MRF_XG_TERM))
         has_term = 1'b1;
end

// frame swallowing holds until the frame's own terminate
always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
      dropping <= 1'b0;
   else if (!dropping && faulted && sop)
      dropping <= 1'b1;
   else if (dropping && has_term)
      dropping <= 1'b0;
end

// output select; local fault outranks remote fault
always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      xgmii_txd <= {8{`MRF_XG_IDLE}};
      xgmii_txc <= 8'hff;
   end
   else if (override)
   begin
      xgmii_txd <= mac_txd;
      xgmii_txc <= mac_txc;
   end
   else if (local_flt)
   begin
      xgmii_txd <= {`MRF_XG_RF_CODE, `MRF_XG_ZERO, `MRF_XG_ZERO, `MRF_XG_SEQ,
                    `MRF_XG_RF_CODE, `MRF_XG_ZERO, `MRF_XG_ZERO, `MRF_XG_SEQ};
      xgmii_txc <= 8'h11;
   end
   else if (remote_flt || dropping || sop)
   begin
      // a start while clear of faults is passed here, in the inner else
      if (remote_flt || dropping)
      begin
         xgmii_txd <= {8{`MRF_XG_IDLE}};
         xgmii_txc <= 8'hff;
      end
      else
      begin
         xgmii_txd <= mac_txd;
         xgmii_txc <= mac_txc;
      end
   end
   else
   begin
      xgmii_txd <= mac_txd;
      xgmii_txc <= mac_txc;
   end
end

endmodule // mrf_fault_gate
`default_nettype wire

/* mrf_pair_buf.v */
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronised active-low reset
`timescale 1ns/1ps
`default_nettype none

module mrf_pair_buf #(
   parameter W = 75
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output reg in_ready,
   input wire [W-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);

reg [W-1:0] slot [0:1];
reg wr_ptr;
reg rd_ptr;
reg [1:0] count;
reg [1:0] next_count;
wire push;
wire pop;

assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;
assign out_data = slot[rd_ptr];

// occupancy; flags are registered so full and empty are exact
always @*
begin
   next_count = count;
   if (push && !pop)
      next_count = count + 2'h1;
   else if (pop && !push)
      next_count = count - 2'h1;
end

always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
   end
   else
   begin
      if (push)
         wr_ptr <= ~wr_ptr;
      if (pop)
         rd_ptr <= ~rd_ptr;
      count <= next_count;
      in_ready <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
   end
end

// storage needs no reset, it is qualified by count
always @(posedge clk)
begin
   if (push)
      slot[wr_ptr] <= in_data;
end

endmodule // mrf_pair_buf
`default_nettype wire

/* mrf_top.v */
// receive client stream, fault status and transmit fault gate
// assumes a decoded receive byte stream and xgmii-coded transmit words on clk
`timescale 1ns/1ps
`default_nettype none
`include "mrf_consts.vh"

// Notes on behaviour
// - local fault received: send remote fault sets
// - remote fault received: send idle words
// - fault bits 28, 29 at word 0x300
// - without management: faults on status bits 0,1
// - frames during fault dropped, no error
// - override set: pass frames, ignore faults
// - 64-bit data with 8-bit lane keep
// - keep bit n marks byte lane n
// - user bit 1 good, 0 bad
// - frame beats leave on consecutive cycles
// - last and status after all checks done
// - last high one cycle per frame
// - receive path held in reset while low
// - status given before next frame data
// - bad on fcs error or under 64 bytes
module mrf_top #(
   parameter HAS_MGMT = 1
) (
   input wire clk,
   input wire reset_n,
   // decoded receive stream from the receive datapath
   input wire rxd_valid,
   output wire rxd_ready,
   input wire [63:0] rxd_data,
   input wire [7:0] rxd_keep,
   input wire rxd_last,
   input wire rxd_fcs_bad,
   input wire rxd_code_bad,
   // client receive stream
   output reg [63:0] rx_axis_tdata,
   output reg [7:0] rx_axis_tkeep,
   output reg rx_axis_tvalid,
   output reg rx_axis_tlast,
   output reg rx_axis_tuser,
   // ordered-set detector levels from the receive side
   input wire link_local_fault,
   input wire link_remote_fault,
   // transmit path
   input wire [63:0] mac_txd,
   input wire [7:0] mac_txc,
   output wire [63:0] xgmii_txd,
   output wire [7:0] xgmii_txc,
   output wire tx_dropping,
   // management access
   input wire [`MRF_ADDR_W-1:0] mgmt_addr,
   input wire mgmt_wr,
   input wire mgmt_rd,
   input wire [31:0] mgmt_wdata,
   output reg [31:0] mgmt_rdata,
   output reg mgmt_rvalid,
   output reg [1:0] status_vector
);

localparam BUF_W = 75;
// config word reset value; only its writable field is taken from it
localparam [31:0] CFG_RST = `MRF_CFG_RESET;

// reset, drain and frame tracking state
reg rst_meta;
reg rst_n_s;
reg run;
reg cfg_override;
reg flt_local;
reg flt_remote;
reg [7:0] byte_cnt;
reg [7:0] next_cnt;
reg [7:0] frame_len;
reg frame_bad;

// buffer side and unpacked beat fields
wire [BUF_W-1:0] buf_in;
wire [BUF_W-1:0] buf_out;
wire buf_valid;
wire buf_ready;
wire beat;
wire [63:0] b_data;
wire [7:0] b_keep;
wire b_last;
wire b_fcs_bad;
wire b_code_bad;
wire [31:0] cfg_word;
wire gate_override;

// management decode
reg cfg_wr;
reg [31:0] next_rdata;

// count of set keep bits, in any lane, on the final beat
function [7:0] lane_count;
   input [7:0] keep;
   integer k;
   begin
      lane_count = 8'h00;
      for (k = 0; k < 8; k = k + 1)
         if (keep[k])
            lane_count = lane_count + 8'h01;
   end
endfunction

// reset release through two flops; assertion stays asynchronous
always @(posedge clk or negedge reset_n)
begin
   if (!reset_n)
   begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
   end
   else
   begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
   end
end

// drain enable comes up one cycle after release so no half beat escapes
always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
      run <= 1'b0;
   else
      run <= 1'b1;
end

// receive stream passes the two-entry buffer
assign buf_in = {rxd_code_bad, rxd_fcs_bad, rxd_last, rxd_keep, rxd_data};
assign buf_ready = run;

mrf_pair_buf #(
   .W(BUF_W)
) u_rx_buf (
   .clk(clk),
   .rst_n(rst_n_s),
   .in_valid(rxd_valid),
   .in_ready(rxd_ready),
   .in_data(buf_in),
   .out_valid(buf_valid),
   .out_ready(buf_ready),
   .out_data(buf_out)
);

// unpack the buffered beat
assign b_data = buf_out[63:0];
assign b_keep = buf_out[71:64];
assign b_last = buf_out[72];
assign b_fcs_bad = buf_out[73];
assign b_code_bad = buf_out[74];
assign beat = buf_valid && buf_ready;

// running byte count, saturates once the minimum is reached
always @*
begin
   next_cnt = byte_cnt;
   frame_len = byte_cnt + lane_count(b_keep);
   if (beat)
   begin
      if (b_last)
         next_cnt = 8'h00;
      else if (byte_cnt < `MRF_MIN_FRAME)
         next_cnt = byte_cnt + `MRF_BEAT_BYTES;
   end
   frame_bad = b_fcs_bad || b_code_bad || (frame_len < `MRF_MIN_FRAME);
end

always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
      byte_cnt <= 8'h00;
   else
      byte_cnt <= next_cnt;
end

// client output stage, every output a flop
always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
   begin
      rx_axis_tdata <= 64'h0000000000000000;
      rx_axis_tkeep <= 8'h00;
      rx_axis_tvalid <= 1'b0;
      rx_axis_tlast <= 1'b0;
      rx_axis_tuser <= 1'b0;
   end
   else if (beat)
   begin
      rx_axis_tdata <= b_data;
      rx_axis_tvalid <= 1'b1;
      rx_axis_tlast <= b_last;
      if (b_last)
      begin
         rx_axis_tkeep <= b_keep;
         rx_axis_tuser <= ~frame_bad;
      end
      else
      begin
         rx_axis_tkeep <= 8'hff;
         rx_axis_tuser <= 1'b0;
      end
   end
   else
   begin
      // idle cycle: nothing qualified, last cannot stretch
      rx_axis_tvalid <= 1'b0;
      rx_axis_tlast <= 1'b0;
      rx_axis_tuser <= 1'b0;
      rx_axis_tkeep <= 8'h00;
   end
end

// fault levels registered once; the detector shares this clock
always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
   begin
      flt_local <= 1'b0;
      flt_remote <= 1'b0;
   end
   else
   begin
      flt_local <= link_local_fault;
      flt_remote <= link_remote_fault;
   end
end

// status vector carries the faults only when no management exists
always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
      status_vector <= 2'h0;
   else if (HAS_MGMT == 0)
   begin
      status_vector[`MRF_SV_LF_BIT] <= flt_local;
      status_vector[`MRF_SV_RF_BIT] <= flt_remote;
   end
   else
      status_vector <= 2'h0; // kept quiet, the config word carries them
end

// configuration word; only the override bit is writable here
assign cfg_word = {2'h0, flt_remote, flt_local, cfg_override, 27'h0000000};

// address decode; other words, or no management at all, read zero
always @*
begin
   cfg_wr = 1'b0;
   next_rdata = 32'h00000000;
   if (HAS_MGMT == 0)
      cfg_wr = 1'b0;
   else if (mgmt_addr == `MRF_CFG_ADDR)
   begin
      cfg_wr = mgmt_wr;
      if (mgmt_rd)
         next_rdata = cfg_word;
   end
   else
      next_rdata = 32'h00000000; // unmapped reads as zero
end

// read data stands only in the cycle of rvalid, zero otherwise
always @(posedge clk or negedge rst_n_s)
begin
   if (!rst_n_s)
   begin
      cfg_override <= CFG_RST[`MRF_OVR_BIT];
      mgmt_rdata <= 32'h00000000;
      mgmt_rvalid <= 1'b0;
   end
   else
   begin
      mgmt_rvalid <= mgmt_rd;
      mgmt_rdata <= next_rdata;
      if (cfg_wr)
         cfg_override <= mgmt_wdata[`MRF_OVR_BIT];
   end
end

// without management the override stays off
assign gate_override = (HAS_MGMT != 0) ? cfg_override : 1'b0;

// transmit gate works from the registered fault levels
mrf_fault_gate u_gate (
   .clk(clk),
   .rst_n(rst_n_s),
   .override(gate_override),
   .local_flt(flt_local),
   .remote_flt(flt_remote),
   .mac_txd(mac_txd),
   .mac_txc(mac_txc),
   .xgmii_txd(xgmii_txd),
   .xgmii_txc(xgmii_txc),
   .dropping(tx_dropping)
);

endmodule // mrf_top
`default_nettype wire

/* mrf_top_assertions.sv */
// port checker for mrf_top: receive stream, management and reset timing
// bound onto every mrf_top instance; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module mrf_top_assertions #(
   parameter HAS_MGMT = 1
) (
   input wire clk,
   input wire reset_n,
   input wire rxd_valid,
   input wire rxd_ready,
   input wire rxd_last,
   input wire [7:0] rx_axis_tkeep,
   input wire rx_axis_tvalid,
   input wire rx_axis_tlast,
   input wire rx_axis_tuser,
   input wire mgmt_rd,
   input wire mgmt_rvalid,
   input wire [1:0] status_vector
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // drain runs every cycle, so latency is fixed at two edges
   chk_beat_latency: assert property (rxd_valid && rxd_ready |-> ##2 rx_axis_tvalid)
      else $error("beat not delivered");
   chk_end_latency: assert property (rxd_valid && rxd_ready && rxd_last |-> ##2 rx_axis_tvalid && rx_axis_tlast)
      else $error("frame end not delivered");
   chk_keep_full: assert property (rx_axis_tvalid && !rx_axis_tlast |-> rx_axis_tkeep == 8'hff)
      else $error("partial keep before end");
   chk_idle_quiet: assert property (!rx_axis_tvalid |-> rx_axis_tkeep == 8'h00 && !rx_axis_tlast && !rx_axis_tuser)
      else $error("stream not quiet when idle");
   chk_user_last: assert property (rx_axis_tuser |-> rx_axis_tlast && rx_axis_tvalid)
      else $error("status outside frame end");
   chk_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
      else $error("read not answered");
   chk_status_quiet: assert property (HAS_MGMT != 0 |-> status_vector == 2'h0)
      else $error("status vector used with management");
   // internal reset copy lifts late, so ready stays low two edges
   chk_ready_reset: assert property ($rose(reset_n) |-> !rxd_ready ##1 !rxd_ready)
      else $error("ready too early after reset");
   cover property (rx_axis_tlast && rx_axis_tuser);
   cover property (rx_axis_tlast && !rx_axis_tuser);
   cover property (mgmt_rvalid);
endmodule // mrf_top_assertions
bind mrf_top mrf_top_assertions #(.HAS_MGMT(HAS_MGMT)) u_chk (.clk, .reset_n, .rxd_valid, .rxd_ready, .rxd_last,
   .rx_axis_tkeep, .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser, .mgmt_rd, .mgmt_rvalid, .status_vector);
`default_nettype wire

/* mrf_top_tb.sv */
// bench: stream rows, then fault gate, management and reset cases
// assumes mrf_top twice, with and without management, and the client model
`timescale 1ns/1ps
`default_nettype none
`include "mrf_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %h, expected %h", $time, (a), (b)); end end
module mrf_top_tb;
   logic clk = 1'b0, reset_n = 1'b0, rxd_valid = 1'b0, rxd_last = 1'b0;
   logic rxd_fcs_bad = 1'b0, rxd_code_bad = 1'b0, link_local_fault = 1'b0;
   logic link_remote_fault = 1'b0, mgmt_wr = 1'b0, mgmt_rd = 1'b0;
   logic [63:0] rxd_data = 64'h0, mac_txd = {8{`MRF_XG_IDLE}};
   logic [7:0] rxd_keep = 8'h00, mac_txc = 8'hff;
   logic [`MRF_ADDR_W-1:0] mgmt_addr = 11'h000;
   logic [31:0] mgmt_wdata = 32'h0;
   wire rxd_ready, rx_axis_tvalid, rx_axis_tlast, rx_axis_tuser, tx_dropping, mgmt_rvalid;
   wire [63:0] rx_axis_tdata, xgmii_txd, xgmii_txd_bare;
   wire [7:0] rx_axis_tkeep, xgmii_txc, xgmii_txc_bare, good_cnt, bad_cnt;
   wire [31:0] mgmt_rdata;
   wire [1:0] status_vector, status_vector_bare;
   int num_errors = 0, tests_run = 0;
   logic [73:0] exp_q[$];
   logic [73:0] got;
   typedef struct packed {logic [3:0] n; logic [7:0] k; logic f, c, g;} mrf_row_t;
   mrf_row_t rows [5];
   localparam logic [63:0] DW = 64'h1122334455667788; // frame body word
   localparam logic [71:0] IDLE = {{8{`MRF_XG_IDLE}}, 8'hff};
   mrf_top u_dut (.clk, .reset_n, .rxd_valid, .rxd_ready, .rxd_data, .rxd_keep, .rxd_last, .rxd_fcs_bad,
      .rxd_code_bad, .rx_axis_tdata, .rx_axis_tkeep, .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser,
      .link_local_fault, .link_remote_fault, .mac_txd, .mac_txc, .xgmii_txd, .xgmii_txc, .tx_dropping,
      .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .status_vector);
   mrf_client_model u_client (.clk, .rx_axis_tvalid, .rx_axis_tlast, .rx_axis_tuser, .good_cnt, .bad_cnt);
   // copy without management: faults show on the status vector, override stays off
   mrf_top #(.HAS_MGMT(0)) u_dut_bare (.clk, .reset_n, .rxd_valid, .rxd_ready(), .rxd_data, .rxd_keep, .rxd_last,
      .rxd_fcs_bad, .rxd_code_bad, .rx_axis_tdata(), .rx_axis_tkeep(), .rx_axis_tvalid(), .rx_axis_tlast(),
      .rx_axis_tuser(), .link_local_fault, .link_remote_fault, .mac_txd, .mac_txc, .xgmii_txd(xgmii_txd_bare),
      .xgmii_txc(xgmii_txc_bare), .tx_dropping(), .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata(),
      .mgmt_rvalid(), .status_vector(status_vector_bare));
   // 50 ns period
   initial forever #25 clk = ~clk;
   // each client beat must match the next one expected
   always @(negedge clk)
      if (rx_axis_tvalid === 1'b1)
      begin
         got = exp_q.size() ? exp_q.pop_front() : 74'h0;
         `CHK({rx_axis_tdata, rx_axis_tkeep, rx_axis_tlast, rx_axis_tuser}, got)
      end
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task give_verdict;
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_ready;
      for (int t = 0; t < 20 && rxd_ready !== 1'b1; t++)
         cyc(1);
      if (rxd_ready !== 1'b1)
      begin
         num_errors++;
         give_verdict;
      end
   endtask
   task rd(input logic [`MRF_ADDR_W-1:0] a, input logic [31:0] e);
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      cyc(1);
      mgmt_rd = 1'b0;
      `CHK({mgmt_rvalid, mgmt_rdata}, {1'b1, e})
      cyc(1);
   endtask
   task wr(input logic [31:0] d);
      mgmt_addr = `MRF_CFG_ADDR;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      cyc(1);
      mgmt_wr = 1'b0;
      cyc(1);
   endtask
   // the gate answers one cycle after the word goes in
   task tx(input logic [63:0] d, input logic [7:0] c);
      mac_txd = d;
      mac_txc = c;
      cyc(1);
   endtask
   initial
   begin
      rows = '{'{4'd8, 8'hff, 1'b0, 1'b0, 1'b1}, '{4'd8, 8'h7f, 1'b0, 1'b0, 1'b0},
         '{4'd9, 8'h01, 1'b0, 1'b0, 1'b1}, '{4'd9, 8'hff, 1'b1, 1'b0, 1'b0}, '{4'd9, 8'hff, 1'b0, 1'b1, 1'b0}};
      cyc(5);
      reset_n = 1'b1;
      wait_ready;
      // frames back to back, no gap between them
      foreach (rows[i])
         for (int b = 1; b <= rows[i].n; b++)
         begin
            rxd_valid = 1'b1;
            rxd_last = (b == rows[i].n);
            rxd_keep = rxd_last ? rows[i].k : 8'h00; // early-beat keep is ignored downstream
            rxd_fcs_bad = rows[i].f;
            rxd_code_bad = rows[i].c;
            rxd_data = {i[7:0], b[7:0], 48'h0123456789ab};
            exp_q.push_back({rxd_data, rxd_last ? rows[i].k : 8'hff, rxd_last, rxd_last & rows[i].g});
            cyc(1);
         end
      rxd_valid = 1'b0;
      rxd_last = 1'b0;
      rxd_data = ~rxd_data;
      cyc(4);
      `CHK(exp_q.size(), 0)
      `CHK({good_cnt, bad_cnt}, {8'h02, 8'h03})
      rd(`MRF_CFG_ADDR, 32'h0);
      rd(11'h304, 32'h0);
      link_remote_fault = 1'b1;
      cyc(3);
      tx(DW, 8'h00);
      `CHK({xgmii_txd, xgmii_txc}, IDLE)
      `CHK(status_vector_bare, 2'h2)
      rd(`MRF_CFG_ADDR, 32'h20000000);
      link_remote_fault = 1'b0;
      link_local_fault = 1'b1;
      cyc(3);
      `CHK({xgmii_txd, xgmii_txc}, {64'h0200009c0200009c, 8'h11})
      rd(`MRF_CFG_ADDR, 32'h10000000);
      `CHK(status_vector, 2'h0)
      `CHK(status_vector_bare, 2'h1)
      // a frame started in the fault is swallowed to its end
      tx({56'h55555555555555, `MRF_XG_START}, 8'h01);
      `CHK(tx_dropping, 1'b1)
      link_local_fault = 1'b0;
      repeat (3) tx(DW, 8'h00);
      `CHK({xgmii_txd, xgmii_txc}, IDLE)
      tx({{7{`MRF_XG_IDLE}}, `MRF_XG_TERM}, 8'hff);
      tx({8{`MRF_XG_IDLE}}, 8'hff);
      `CHK(tx_dropping, 1'b0)
      tx(DW, 8'h00);
      `CHK({xgmii_txd, xgmii_txc}, {DW, 8'h00})
      wr(32'h08000000);
      link_local_fault = 1'b1;
      cyc(3);
      tx(DW, 8'h00);
      `CHK({xgmii_txd, xgmii_txc}, {DW, 8'h00})
      `CHK({xgmii_txd_bare, xgmii_txc_bare}, {64'h0200009c0200009c, 8'h11})
      rd(`MRF_CFG_ADDR, 32'h18000000);
      // reset in mid-run drops a beat held in the buffer
      link_local_fault = 1'b0;
      rxd_valid = 1'b1;
      cyc(1);
      rxd_valid = 1'b0;
      reset_n = 1'b0;
      cyc(2);
      `CHK({rx_axis_tvalid, rxd_ready}, 2'b00)
      reset_n = 1'b1;
      wait_ready;
      rd(`MRF_CFG_ADDR, 32'h0);
      `CHK(status_vector_bare, 2'h0)
      give_verdict;
   end
endmodule // mrf_top_tb
`default_nettype wire
